// file: cpcs_ctrl.sv
`timescale 1ns/1ps
`include "cpcs_consts.svh"

// Summary of operation
// - clear exceptions: group 011, E2, 11 clocks
// - store environment: group 001 reg 110, 104
// - load environment: group 001 reg 100, 71
// - restore full state: group 101 reg 100
// - stack top increment: F7, 21 clocks
// - stack top decrement: F6, 22 clocks
// - no operation: D0, 12 clocks
// - trig reduction adds 76 clocks
// - error line goes straight to host
// - legacy irq opcodes change nothing
// - fault address is first prefix byte if prefixed, else instr_addr
// - protected mode: no opcode saved
// - busy held until instruction completes

module cpcs_ctrl
    import cpcs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // instruction issue from host
    input wire logic issue,
    input wire cpcs_pkg::cpcs_instr_s instr,
    input wire logic protected_mode,
    // numeric fault from the datapath
    input wire logic numeric_fault,
    // status toward host
    output logic busy,
    output logic error,
    output logic [2:0] stack_top,
    output logic exc_clear,
    output cpcs_pkg::cpcs_ptr_s saved_ptr,
    output cpcs_pkg::cpcs_op_e cur_op
);
    import cpcs_pkg::*;

    cpcs_op_e dec_op;
    logic [8:0] dec_clocks;

    cpcs_decode u_decode (
        .group(instr.group),
        .byte1(instr.byte1),
        .op(dec_op),
        .clocks(dec_clocks)
    );

    cpcs_state_e state_r, state_nxt;
    cpcs_op_e op_r, op_nxt;
    logic [9:0] cnt_r, cnt_nxt;
    logic busy_r, busy_nxt;
    logic error_r, error_nxt;
    logic [2:0] top_r, top_nxt;
    logic clr_r, clr_nxt;
    cpcs_ptr_s ptr_r, ptr_nxt;
    logic accept;
    logic [9:0] total;

    // an issue while busy is dropped; host must wait on busy
    assign accept = issue && (state_r == CPCS_IDLE)
        && (dec_op != CPCS_NONE);

    always_comb
    begin
        state_nxt = state_r;
        op_nxt = op_r;
        cnt_nxt = cnt_r;
        busy_nxt = busy_r;
        error_nxt = error_r;
        top_nxt = top_r;
        clr_nxt = 1'b0;
        ptr_nxt = ptr_r;
        total = {1'b0, dec_clocks};
        if (instr.trig_reduce)
        begin
            total = 10'({1'b0, dec_clocks}
                + {1'b0, `CPCS_CLK_REDUCE});
        end
        // fault raises the dedicated line; set wins over clear
        if (numeric_fault)
        begin
            error_nxt = 1'b1;
            // with a prefix, record the first prefix byte, not the escape byte; else instr_addr
            ptr_nxt.instr_ptr = instr.has_prefix ? instr.prefix_addr
                : instr.instr_addr;
            ptr_nxt.oper_ptr = instr.oper_addr;
            ptr_nxt.prot_fmt = protected_mode;
            ptr_nxt.opcode = protected_mode ? 11'h000
                : {instr.group, instr.byte1};
        end
        case (state_r)
            CPCS_IDLE:
            begin
                if (accept)
                begin
                    op_nxt = dec_op;
                    // busy then stands exactly total cycles
                    cnt_nxt = total;
                    busy_nxt = 1'b1;
                    state_nxt = CPCS_BUSY;
                    if (dec_op == CPCS_CLEX && !numeric_fault)
                    begin
                        error_nxt = 1'b0;
                        clr_nxt = 1'b1;
                    end
                    else if (dec_op == CPCS_INCSTP)
                    begin
                        top_nxt = 3'(top_r + 3'd1);
                    end
                    else if (dec_op == CPCS_DECSTP)
                    begin
                        top_nxt = 3'(top_r - 3'd1);
                    end
                    // nop and legacy irq ops touch no state
                end
            end
            CPCS_BUSY:
            begin
                if (cnt_r <= 10'd1)
                begin
                    busy_nxt = 1'b0;
                    op_nxt = CPCS_NONE;
                    state_nxt = CPCS_IDLE;
                    cnt_nxt = 10'd0;
                end
                else
                begin
                    cnt_nxt = cnt_r - 10'd1;
                end
            end
            default:
            begin
                state_nxt = CPCS_IDLE;
                busy_nxt = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock)
    begin
        if (reset)
        begin
            state_r <= CPCS_IDLE;
            op_r <= CPCS_NONE;
            cnt_r <= 10'd0;
            busy_r <= 1'b0;
            error_r <= 1'b0;
            top_r <= `CPCS_TOP_RST;
            clr_r <= 1'b0;
            ptr_r <= '0;
        end
        else
        begin
            state_r <= state_nxt;
            op_r <= op_nxt;
            cnt_r <= cnt_nxt;
            busy_r <= busy_nxt;
            error_r <= error_nxt;
            top_r <= top_nxt;
            clr_r <= clr_nxt;
            ptr_r <= ptr_nxt;
        end
    end

    assign busy = busy_r;
    assign error = error_r;
    assign stack_top = top_r;
    assign exc_clear = clr_r;
    assign saved_ptr = ptr_r;
    assign cur_op = op_r;

endmodule

// file: cpcs_consts.svh
`ifndef CPCS_CONSTS_SVH
`define CPCS_CONSTS_SVH

// escape groups (low three bits of the first opcode byte)
`define CPCS_GRP_001 3'h1
`define CPCS_GRP_011 3'h3
`define CPCS_GRP_101 3'h5
// register-form second bytes
`define CPCS_B1_CLEX 8'hE2
`define CPCS_B1_INCSTP 8'hF7
`define CPCS_B1_DECSTP 8'hF6
`define CPCS_B1_NOP 8'hD0
// legacy irq opcodes, escape group 011
`define CPCS_B1_LEG_EN 8'hE0
`define CPCS_B1_LEG_DIS 8'hE1
// reg field of memory forms
`define CPCS_REG_STORE 3'h6
`define CPCS_REG_LOAD 3'h4
// memory-form mod value that selects register form
`define CPCS_MOD_REG 2'h3
// execution clocks
`define CPCS_CLK_CLEX 9'd11
`define CPCS_CLK_STENV 9'd104
`define CPCS_CLK_LDENV 9'd71
`define CPCS_CLK_SAVE 9'd376
`define CPCS_CLK_RSTOR 9'd308
`define CPCS_CLK_INCSTP 9'd21
`define CPCS_CLK_DECSTP 9'd22
`define CPCS_CLK_NOP 9'd12
`define CPCS_CLK_IGNORE 9'd1
`define CPCS_CLK_REDUCE 9'd76
// reset values
`define CPCS_TOP_RST 3'h0
`define CPCS_ADDR_RST 32'h0000_0000

`endif

// file: cpcs_pkg.sv
package cpcs_pkg;

    typedef enum logic [8:0] {
        CPCS_NONE = 9'h000,
        CPCS_CLEX = 9'h001,
        CPCS_STENV = 9'h002,
        CPCS_LDENV = 9'h004,
        CPCS_SAVE = 9'h008,
        CPCS_RSTOR = 9'h010,
        CPCS_INCSTP = 9'h020,
        CPCS_DECSTP = 9'h040,
        CPCS_NOP = 9'h080,
        CPCS_IGNORE = 9'h100
    } cpcs_op_e;

    typedef enum logic [1:0] {
        CPCS_IDLE = 2'h1,
        CPCS_BUSY = 2'h2
    } cpcs_state_e;

    // instruction as delivered by the host
    typedef struct packed {
        logic [2:0] group;
        logic [7:0] byte1;
        logic [31:0] instr_addr;
        logic [31:0] oper_addr;
        logic has_prefix;
        logic [31:0] prefix_addr;
        logic trig_reduce;
    } cpcs_instr_s;

    // pointers recorded on a numeric fault
    typedef struct packed {
        logic [31:0] instr_ptr;
        logic [31:0] oper_ptr;
        logic [10:0] opcode;
        logic prot_fmt;
    } cpcs_ptr_s;

endpackage

// file: cpcs_decode.sv
`timescale 1ns/1ps
`include "cpcs_consts.svh"

module cpcs_decode
    import cpcs_pkg::*;
(
    // instruction bytes
    input wire logic [2:0] group,
    input wire logic [7:0] byte1,
    // decoded operation and its clocks
    output cpcs_pkg::cpcs_op_e op,
    output logic [8:0] clocks
);
    import cpcs_pkg::*;

    logic mem_form;
    logic [2:0] reg_f;

    always_comb
    begin
        mem_form = (byte1[7:6] != `CPCS_MOD_REG);
        reg_f = byte1[5:3];
        op = CPCS_NONE;
        clocks = 9'd0;
        case (group)
            `CPCS_GRP_011:
            begin
                if (byte1 == `CPCS_B1_CLEX)
                begin
                    op = CPCS_CLEX;
                    clocks = `CPCS_CLK_CLEX;
                end
                else if (byte1 == `CPCS_B1_LEG_EN
                         || byte1 == `CPCS_B1_LEG_DIS)
                begin
                    op = CPCS_IGNORE;
                    clocks = `CPCS_CLK_IGNORE;
                end
            end
            `CPCS_GRP_001:
            begin
                if (mem_form && reg_f == `CPCS_REG_STORE)
                begin
                    op = CPCS_STENV;
                    clocks = `CPCS_CLK_STENV;
                end
                else if (mem_form && reg_f == `CPCS_REG_LOAD)
                begin
                    op = CPCS_LDENV;
                    clocks = `CPCS_CLK_LDENV;
                end
                else if (byte1 == `CPCS_B1_INCSTP)
                begin
                    op = CPCS_INCSTP;
                    clocks = `CPCS_CLK_INCSTP;
                end
                else if (byte1 == `CPCS_B1_DECSTP)
                begin
                    op = CPCS_DECSTP;
                    clocks = `CPCS_CLK_DECSTP;
                end
                else if (byte1 == `CPCS_B1_NOP)
                begin
                    op = CPCS_NOP;
                    clocks = `CPCS_CLK_NOP;
                end
            end
            `CPCS_GRP_101:
            begin
                if (mem_form && reg_f == `CPCS_REG_STORE)
                begin
                    op = CPCS_SAVE;
                    clocks = `CPCS_CLK_SAVE;
                end
                else if (mem_form && reg_f == `CPCS_REG_LOAD)
                begin
                    op = CPCS_RSTOR;
                    clocks = `CPCS_CLK_RSTOR;
                end
            end
            default:
            begin
                op = CPCS_NONE;
                clocks = 9'd0;
            end
        endcase
    end

endmodule

// file: cpcs_ctrl_props.sv
`timescale 1ns/1ps

module cpcs_ctrl_props
    import cpcs_pkg::*;
(
    // clock and reset
    input wire logic clock,
    input wire logic reset,
    // host side
    input wire logic issue,
    input wire cpcs_pkg::cpcs_instr_s instr,
    input wire logic protected_mode,
    input wire logic numeric_fault,
    // status
    input wire logic busy,
    input wire logic error,
    input wire logic [2:0] stack_top,
    input wire logic exc_clear,
    input wire cpcs_pkg::cpcs_ptr_s saved_ptr,
    input wire cpcs_pkg::cpcs_op_e cur_op
);
    default clocking @(posedge clock); endclocking
    default disable iff (reset);
    logic [8:0] cnt_r;
    cpcs_op_e op_r;
    logic trig_r;

    // upper value of each range is the one we hold the design to
    function automatic logic [8:0] span(input cpcs_op_e op);
        case (op)
            CPCS_CLEX: span = 9'h00B;
            CPCS_STENV: span = 9'h068;
            CPCS_LDENV: span = 9'h047;
            CPCS_SAVE: span = 9'h178;
            CPCS_RSTOR: span = 9'h134;
            CPCS_INCSTP: span = 9'h015;
            CPCS_DECSTP: span = 9'h016;
            CPCS_NOP: span = 9'h00C;
            default: span = 9'h001;
        endcase
    endfunction

    always_ff @(posedge clock)
    begin
        cnt_r <= (reset || !busy) ? 9'h000 : cnt_r + 9'h001;
        op_r <= busy ? cur_op : op_r;
        if (issue && !busy)
            trig_r <= instr.trig_reduce;
    end

    busy_span_a: assert property ($fell(busy) |-> cnt_r == span(op_r)
        + (trig_r ? 9'h04C : 9'h000)) else $error("busy length wrong");
    take_busy_a: assert property (issue && !busy && instr.group == 3'h1
        && instr.byte1 == 8'hD0 |=> busy && cur_op == CPCS_NOP)
        else $error("nop not taken");
    stack_inc_a: assert property ($rose(busy) && cur_op == CPCS_INCSTP
        |-> stack_top == $past(stack_top) + 3'h1) else $error("no increment");
    stack_dec_a: assert property ($rose(busy) && cur_op == CPCS_DECSTP
        |-> stack_top == $past(stack_top) - 3'h1) else $error("no decrement");
    quiet_ops_a: assert property (cur_op == CPCS_NOP || cur_op == CPCS_IGNORE
        |-> $stable(stack_top)) else $error("quiet op moved stack top");
    fault_set_a: assert property (numeric_fault |=> error)
        else $error("fault did not set error");
    prefix_ptr_a: assert property (numeric_fault && instr.has_prefix |=>
        saved_ptr.instr_ptr == $past(instr.prefix_addr))
        else $error("pointer not at prefix");
    prot_ptr_a: assert property (numeric_fault && protected_mode |=>
        saved_ptr.opcode == 11'h000 && saved_ptr.prot_fmt)
        else $error("protected pointer wrong");
    clear_err_a: assert property (exc_clear |-> ##[0:1] !error)
        else $error("error not cleared");
endmodule

bind cpcs_ctrl cpcs_ctrl_props chk (.clock, .reset, .issue, .instr,
    .protected_mode, .numeric_fault, .busy, .error, .stack_top, .exc_clear,
    .saved_ptr, .cur_op);

// file: cpcs_host.sv
`timescale 1ns/1ps

module cpcs_host
    import cpcs_pkg::*;
(
    // clock and coprocessor status
    input wire logic clock,
    input wire logic busy,
    // command from the bench
    input wire logic go,
    input wire logic as_fault,
    input wire cpcs_pkg::cpcs_instr_s cmd,
    // toward the coprocessor
    output logic issue,
    output logic numeric_fault,
    output cpcs_pkg::cpcs_instr_s instr
);
    logic pend_r = 1'b0;
    initial issue = 1'b0;
    initial numeric_fault = 1'b0;
    initial instr = '0;

    // traps 7, 9 and 13 stay in the host: none are raised here
    always @(posedge clock)
    begin
        issue <= 1'b0;
        numeric_fault <= 1'b0;
        instr <= ~instr;
        pend_r <= pend_r || go;
        if ((pend_r || go) && !busy)
        begin
            pend_r <= 1'b0;
            instr <= cmd;
            issue <= !as_fault;
            numeric_fault <= as_fault;
        end
    end
endmodule

// file: coproc_control_ops_host_sync_tb.sv
`timescale 1ns/1ps

module coproc_control_ops_host_sync_tb;
    import cpcs_pkg::*;
    logic clock = 1'b0;
    logic reset = 1'b1;
    logic protected_mode = 1'b0;
    logic go = 1'b0;
    logic as_fault = 1'b0;
    cpcs_instr_s cmd = '0;
    logic issue, numeric_fault, busy, error, exc_clear;
    logic [2:0] stack_top;
    cpcs_instr_s instr;
    cpcs_ptr_s saved_ptr;
    cpcs_op_e cur_op;
    int n_mismatch = 0;
    int checks = 0;
    int cyc = 0;

    initial forever #2.5 clock = ~clock;
    cpcs_host host (.clock, .busy, .go, .as_fault, .cmd, .issue,
        .numeric_fault, .instr);
    cpcs_ctrl dut (.clock, .reset, .issue, .instr, .protected_mode,
        .numeric_fault, .busy, .error, .stack_top, .exc_clear, .saved_ptr,
        .cur_op);

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("unexpected %s expected %0h seen %0h", what, exp, seen);
        end
    endtask

    task automatic send(input logic [2:0] g, input logic [7:0] b,
        input logic f);
        @(negedge clock);
        cmd.group = g;
        cmd.byte1 = b;
        as_fault = f;
        go = 1'b1;
        @(negedge clock);
        go = 1'b0;
    endtask

    // bounded waits so a stuck busy cannot hang the run
    task automatic run(input logic [2:0] g, input logic [7:0] b,
        input cpcs_op_e op, input logic [31:0] len);
        int n;
        n = 0;
        send(g, b, 1'b0);
        while (busy !== 1'b1 && n < 8)
        begin
            @(negedge clock);
            n++;
        end
        chk("cur_op", cur_op, op);
        n = 0;
        while (busy === 1'b1 && n < 500)
        begin
            @(negedge clock);
            n++;
        end
        chk("busy cycles", n, len);
    endtask

    task automatic t_ops();
        run(3'h1, 8'hF6, CPCS_DECSTP, 32'h16);
        chk("stack_top", stack_top, 32'h7);
        run(3'h1, 8'hF7, CPCS_INCSTP, 32'h15);
        chk("stack_top", stack_top, 32'h0);
        run(3'h1, 8'hD0, CPCS_NOP, 32'h0C);
        chk("stack_top", stack_top, 32'h0);
        run(3'h1, 8'h30, CPCS_STENV, 32'h68);
        run(3'h1, 8'h20, CPCS_LDENV, 32'h47);
        run(3'h5, 8'h30, CPCS_SAVE, 32'h178);
        run(3'h5, 8'h20, CPCS_RSTOR, 32'h134);
        cmd.trig_reduce = 1'b1;
        run(3'h1, 8'hD0, CPCS_NOP, 32'h58);
        cmd.trig_reduce = 1'b0;
        $display("test ops done");
    endtask

    task automatic t_fault();
        cmd.has_prefix = 1'b1;
        cmd.prefix_addr = 32'h0000_1230;
        cmd.instr_addr = 32'h0000_1232;
        cmd.oper_addr = 32'h0000_4560;
        send(3'h1, 8'hD0, 1'b1);
        @(negedge clock);
        chk("error", error, 32'h1);
        chk("oper_ptr", saved_ptr.oper_ptr, 32'h4560);
        chk("instr_ptr", saved_ptr.instr_ptr, 32'h1230);
        chk("opcode", saved_ptr.opcode, 32'h1D0);
        protected_mode = 1'b1;
        send(3'h1, 8'hD0, 1'b1);
        @(negedge clock);
        chk("opcode", saved_ptr.opcode, 32'h0);
        chk("prot_fmt", saved_ptr.prot_fmt, 32'h1);
        protected_mode = 1'b0;
        run(3'h3, 8'hE0, CPCS_IGNORE, 32'h1);
        run(3'h3, 8'hE1, CPCS_IGNORE, 32'h1);
        chk("error", error, 32'h1);
        chk("stack_top", stack_top, 32'h0);
        run(3'h3, 8'hE2, CPCS_CLEX, 32'h0B);
        chk("error", error, 32'h0);
        $display("test fault done");
    endtask

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 4000)
        begin
            n_mismatch++;
            tally_and_finish();
        end
    end

    initial
    begin
        repeat (6) @(posedge clock);
        @(negedge clock);
        reset = 1'b0;
        t_ops();
        t_fault();
        tally_and_finish();
    end
endmodule
